// file: inc/synth_cfg_pkg.sv
// Purpose: constants, bus carriers and register layout for the divider block
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes:   all offsets and field positions live here
// ==========================================================================
`default_nettype none
package synth_cfg_pkg;
  // ========================================================================
  // Register map
  localparam logic [7:0] REG_CTRL0  = 8'h00;
  localparam logic [7:0] REG_REFDIV = 8'h04;
  localparam logic [7:0] REG_NINT   = 8'h08;
  localparam logic [7:0] REG_NUM    = 8'h0c;
  localparam logic [7:0] REG_BOTTOM = 8'h10;
  localparam logic [7:0] REG_EXTRA  = 8'h14;
  localparam logic [7:0] REG_PHASE  = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;

  // ========================================================================
  // Field positions
  localparam int DBL_BIT    = 0;
  localparam int SEL_BIT    = 2;
  localparam int CAL_BIT    = 3;
  localparam int ORDER_LSB  = 4;
  localparam int LDTYPE_BIT = 6;
  localparam int SYNC_BIT   = 7;
  localparam int PRE_LSB    = 0;
  localparam int POST_LSB   = 8;
  localparam int SMDIV_LSB  = 16;
  localparam int DLY_LSB    = 20;
  localparam int ST_BUSY    = 24;
  localparam int ST_LOCK    = 25;
  localparam int ST_PIN     = 26;

  // ========================================================================
  // Limits, reset values and response codes
  localparam logic [7:0]  PRE_MAX   = 8'h80;
  localparam logic [7:0]  POST_MAX  = 8'hff;
  localparam logic [2:0]  SM_MAX    = 3'h5;
  localparam logic [18:0] NINT_MIN  = 19'h0001c;
  localparam logic [18:0] NINT_RST  = 19'h00064;
  localparam logic [31:0] BOT_RST   = 32'h000003e8;
  localparam logic [2:0]  DLY_RST   = 3'h1;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  // ========================================================================
  // Bus carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
endpackage : synth_cfg_pkg
`default_nettype wire

// file: verif/host_master.sv
// Purpose: AXI4-Lite host model for the divider register bus
// Assumes: one write or one read at a time
// Notes:   released payload shows its inverse, not the last value
`timescale 1ns/1ps
`default_nettype none
module host_master import synth_cfg_pkg::*; (
  // Clock
  input  wire logic      core_clk,
  // Bus
  output var  axil_req_t req,
  input  wire axil_rsp_t rsp
);
  // ==========================================================
  // Transfers
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    // Ready is combinational: look at it settled, then take it at the next rise
    do @(negedge core_clk); while (!(rsp.awready && rsp.wready));
    @(posedge core_clk);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    req.awaddr  <= ~a;
    req.wdata   <= ~d;
    do @(negedge core_clk); while (!rsp.bvalid);
    r = rsp.bresp;
    @(posedge core_clk);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(negedge core_clk); while (!rsp.arready);
    @(posedge core_clk);
    req.arvalid <= 1'b0;
    req.araddr  <= ~a;
    do @(negedge core_clk); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge core_clk);
    req.rready <= 1'b0;
  endtask : rd
endmodule : host_master
`default_nettype wire

// file: verif/test_fractional_n_divider_config.sv
// Purpose: self-checking bench for the divider configuration block
// Assumes: reference period 160 ns, well below core_clk / 4
// Notes:   tick rates checked within one tick of the ideal count
`timescale 1ns/1ps
`default_nettype none
module test_fractional_n_divider_config import synth_cfg_pkg::*;;
  typedef struct packed {
    logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;
  } row_t;
  logic        core_clk, reset, clk_en, ref_in, busy, lockp, rb, pin, oe, dt, st, cal;
  logic [1:0]  ord, resp;
  logic [2:0]  dly;
  logic [7:0]  xf;
  logic [20:0] fdiv;
  logic [31:0] data;
  axil_req_t   req;
  axil_rsp_t   rsp;
  int          failures, checks_done, cyc, nd, ns, nc, d0, s0;
  row_t rows [10] = '{
    '{REG_REFDIV, 32'h0030_0000, 32'h0030_0101, RESP_OK},
    '{REG_REFDIV, 32'h0017_0381, 32'h0015_0380, RESP_OK},
    '{REG_NINT, 32'h0000_001b, 32'h0000_001c, RESP_OK},
    '{REG_NINT, 32'h0007_ffff, 32'h0007_ffff, RESP_OK},
    '{REG_BOTTOM, 32'h0, 32'h1, RESP_OK},
    '{REG_BOTTOM, 32'hffff_ffff, 32'hffff_ffff, RESP_OK},
    '{REG_EXTRA, 32'h0, 32'h1, RESP_OK},
    '{REG_PHASE, 32'h0000_0010, 32'h0000_0010, RESP_OK},
    '{REG_CTRL0, 32'h0000_0038, 32'h0000_0030, RESP_OK},
    '{8'h20, 32'h0000_1234, 32'h0, RESP_ERR}};
  // ==========================================================
  // Instances
  host_master i_host (.core_clk(core_clk), .req(req), .rsp(rsp));
  fractional_n_divider_config i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .bus_req(req), .bus_rsp(rsp), .reference_input(ref_in), .cal_busy_pin(busy),
    .vtune_locked_pin(lockp), .readback_bit(rb), .status_pin_out(pin), .status_pin_oe(oe),
    .detector_tick(dt), .sm_tick(st), .calibration_start(cal), .modulator_order(ord),
    .detector_delay_select(dly), .feedback_extra_factor(xf), .feedback_divide(fdiv));
  // ==========================================================
  // Clocks, counters, timeout
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always #80 ref_in = ~ref_in;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    nd  <= nd + int'(dt);
    ns  <= ns + int'(st);
    nc  <= nc + int'(cal);
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic rates(input int dexp, input int sexp);
    d0 = nd;
    s0 = ns;
    repeat (1920) @(posedge core_clk);
    check(32'((nd - d0) >= dexp - 1 && (nd - d0) <= dexp + 1), 32'h1);
    check(32'((ns - s0) >= sexp - 1 && (ns - s0) <= sexp + 1), 32'h1);
  endtask : rates
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold
  // ==========================================================
  // Sequence
  initial begin
    {reset, clk_en, ref_in, busy, lockp, rb} = 6'b110100;
    {failures, checks_done, cyc, nd, ns, nc} = '0;
    hold(20);
    reset <= 1'b0;
    // reference already running before the calibration write
    foreach (rows[i]) begin
      i_host.wr(rows[i].a, rows[i].d, resp);
      check(32'(resp), 32'(rows[i].r));
      i_host.rd(rows[i].a, data, resp);
      check(data, rows[i].q);
      check(32'(resp), 32'(rows[i].r));
    end
    check(32'(nc), 32'h1);
    reset <= 1'b1;
    hold(2);
    reset <= 1'b0;
    i_host.rd(REG_REFDIV, data, resp);
    check(data, 32'h0010_0101);
    check(32'(dly), 32'(DLY_RST));
    for (int k = 0; k < 4; k++) begin
      i_host.wr(REG_CTRL0, 32'(k) << ORDER_LSB, resp);
      check(32'(ord), 32'(k));
    end
    rb <= 1'b1;
    hold(3);
    check(32'({pin, oe}), 32'h3);
    rb <= 1'b0;
    hold(3);
    check(32'({pin, oe}), 32'h1);
    i_host.wr(REG_CTRL0, 32'h4, resp);
    busy <= 1'b0;
    hold(5);
    check(32'(pin), 32'h1);
    i_host.wr(REG_CTRL0, 32'h44, resp);
    hold(5);
    check(32'(pin), 32'h0);
    lockp <= 1'b1;
    hold(5);
    check(32'(pin), 32'h1);
    i_host.wr(REG_EXTRA, 32'h5, resp);
    i_host.wr(REG_CTRL0, 32'h0, resp);
    check(32'(xf), 32'h1);
    i_host.wr(REG_CTRL0, 32'h80, resp);
    check(32'(xf), 32'h5);
    // slow reference keeps post input far below its limit
    // no channel divide is ever programmed, so its 10 GHz cap holds
    i_host.wr(REG_REFDIV, 32'h0013_0302, resp);
    i_host.wr(REG_CTRL0, 32'h0, resp);
    rates(20, 15);
    i_host.wr(REG_CTRL0, 32'h1, resp);
    rates(40, 15);
    // integer value above the order 0 floor
    i_host.wr(REG_NINT, 32'd40, resp);
    hold(300);
    check(32'(fdiv), 32'd40);
    i_host.rd(REG_STATUS, data, resp);
    check(data, 32'h0200_0028);
    // frozen clock enable holds the pin
    clk_en <= 1'b0;
    rb     <= 1'b1;
    hold(5);
    check(32'(pin), 32'h0);
    clk_en <= 1'b1;
    hold(3);
    check(32'(pin), 32'h1);
    give_verdict();
  end
endmodule : test_fractional_n_divider_config
`default_nettype wire

// file: verilog/fraction_modulator.sv
// Purpose: MASH 1-1-1 delta-sigma engine giving the per-cycle feedback divide
// Assumes: fraction top below fraction bottom; one tick per detector cycle
// Notes:   a pending phase step is folded into the first accumulator
`timescale 1ns/1ps
`default_nettype none
module fraction_modulator import synth_cfg_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Control
  input  wire logic        clear,
  input  wire logic        tick,
  input  wire logic [1:0]  order,
  input  wire logic [18:0] nint,
  input  wire logic [31:0] num,
  input  wire logic [31:0] bottom,
  input  wire logic        phase_add,
  input  wire logic [31:0] phase_step,
  // Result
  output var  logic [20:0] divide
);
  typedef struct packed {
    logic [31:0] acc1, acc2, acc3;
    logic        c2d, c3d, c3dd, pend;
    logic [20:0] div;
  } mod_t;

  mod_t st, nx;

  function automatic logic [32:0] acc_step(input logic [31:0] acc,
                                           input logic [31:0] add,
                                           input logic [31:0] bot);
    logic [33:0] s;
    logic        c;
    s = {2'b00, acc} + {2'b00, add};
    c = (s >= {2'b00, bot});
    if (c) begin
      s = s - {2'b00, bot};
    end
    return {c, s[31:0]};
  endfunction : acc_step

  logic [32:0]        r1, r2, r3;
  logic [31:0]        add1;
  logic signed [3:0]  delta;
  logic signed [21:0] sum;

  always_comb begin
    nx    = st;
    add1  = st.pend ? num + phase_step : num;
    r1    = acc_step(st.acc1, add1, bottom);
    r2    = acc_step(st.acc2, r1[31:0], bottom);
    r3    = acc_step(st.acc3, r2[31:0], bottom);
    delta = 4'sd0;
    case (order)
      2'd1: delta = $signed({3'b000, r1[32]});
      2'd2: delta = $signed({3'b000, r1[32]}) + $signed({3'b000, r2[32]})
                    - $signed({3'b000, st.c2d});
      2'd3: delta = $signed({3'b000, r1[32]}) + $signed({3'b000, r2[32]})
                    - $signed({3'b000, st.c2d}) + $signed({3'b000, r3[32]})
                    - $signed({2'b00, st.c3d, 1'b0}) + $signed({3'b000, st.c3dd});
      default: delta = 4'sd0;
    endcase
    sum = $signed({3'b000, nint}) + 22'(delta);
    nx.pend = st.pend | phase_add;
    if (tick) begin
      nx.div = sum[20:0];
      if (order != 2'd0) begin
        nx.acc1 = r1[31:0];
        nx.acc2 = r2[31:0];
        nx.acc3 = r3[31:0];
        nx.c2d  = r2[32];
        nx.c3d  = r3[32];
        nx.c3dd = st.c3d;
        nx.pend = phase_add;
      end
    end
    if (clear) begin
      nx.acc1 = '0;
      nx.acc2 = '0;
      nx.acc3 = '0;
      nx.c2d  = 1'b0;
      nx.c3d  = 1'b0;
      nx.c3dd = 1'b0;
      nx.pend = phase_add;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  assign divide = st.div;

  chk_order0_int: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && tick && order == 2'd0) |=> divide == {2'b00, $past(nint)})
    else $error("integer order gave fractional divide");
  chk_clear_acc: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && clear) |=> (st.acc1 == '0 && st.acc2 == '0 && st.acc3 == '0))
    else $error("modulator not cleared");
  chk_order1_range: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && tick && order == 2'd1) |=>
      (divide - {2'b00, $past(nint)}) <= 21'd1)
    else $error("first order divide out of range");
endmodule : fraction_modulator
`default_nettype wire

// file: verilog/fractional_n_divider_config.sv
// Purpose: reference path, state machine clock, feedback control and status pin
// Assumes: reference_input is asynchronous and well below core_clk / 4
// Notes:   registers over AXI4-Lite; write address and data taken together
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fractional_n_divider_config import synth_cfg_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Register bus
  input  wire axil_req_t   bus_req,
  output var  axil_rsp_t   bus_rsp,
  // Pins and sense inputs
  input  wire logic        reference_input,
  input  wire logic        cal_busy_pin,
  input  wire logic        vtune_locked_pin,
  input  wire logic        readback_bit,
  // Status pin
  output var  logic        status_pin_out,
  output var  logic        status_pin_oe,
  // Divider control
  output var  logic        detector_tick,
  output var  logic        sm_tick,
  output var  logic        calibration_start,
  output var  logic [1:0]  modulator_order,
  output var  logic [2:0]  detector_delay_select,
  output var  logic [7:0]  feedback_extra_factor,
  output var  logic [20:0] feedback_divide
);
  // ========================================================================
  // State
  typedef struct packed {
    logic [2:0]  ref_pipe;
    logic [1:0]  busy_pipe;
    logic [1:0]  lock_pipe;
    logic        dbl;
    logic        sel;
    logic        lock_indicator_type;
    logic        sync_mode;
    logic [1:0]  order;
    logic [7:0]  pre_div;
    logic [7:0]  post_div;
    logic [7:0]  extra;
    logic [2:0]  sm_code;
    logic [2:0]  dly;
    logic [18:0] nint;
    logic [31:0] num;
    logic [31:0] bottom;
    logic [31:0] phase_step;
    logic [7:0]  pre_cnt;
    logic [7:0]  post_cnt;
    logic [4:0]  sm_cnt;
    logic        pd_tick;
    logic        smt;
    logic        cal;
    logic        mod_clear;
    logic        phase_add;
    logic        pin;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

  localparam state_t ST_RST = '{
    pre_div:  8'h01,
    post_div: 8'h01,
    extra:    8'h01,
    nint:     NINT_RST,
    bottom:   BOT_RST,
    dly:      DLY_RST,
    default:  '0
  };

  state_t      st;
  state_t      nx;
  logic [20:0] mod_divide;

  // ========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Zero means bypass; values past the top saturate
  function automatic logic [7:0] clamp_div(input logic [7:0] v,
                                           input logic [7:0] top);
    if (v == 8'h00) begin
      return 8'h01;
    end else if (v > top) begin
      return top;
    end
    return v;
  endfunction : clamp_div

  function automatic logic [31:0] ctrl_word(input state_t s);
    logic [31:0] w;
    w = '0;
    w[DBL_BIT]              = s.dbl;
    w[SEL_BIT]              = s.sel;
    w[ORDER_LSB +: 2]       = s.order;
    w[LDTYPE_BIT]           = s.lock_indicator_type;
    w[SYNC_BIT]             = s.sync_mode;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] refdiv_word(input state_t s);
    logic [31:0] w;
    w = '0;
    w[PRE_LSB +: 8]   = s.pre_div;
    w[POST_LSB +: 8]  = s.post_div;
    w[SMDIV_LSB +: 3] = s.sm_code;
    w[DLY_LSB +: 3]   = s.dly;
    return w;
  endfunction : refdiv_word

  // ========================================================================
  // Bus handshake
  logic        wr_go;
  logic        rd_go;
  logic [31:0] wv;
  logic        rise;
  logic        ref_edge;
  logic        pre_hit;
  logic        indicator;

  assign wr_go = clk_en && bus_req.awvalid && bus_req.wvalid && !st.bvalid;
  assign rd_go = clk_en && bus_req.arvalid && !st.rvalid;

  always_comb begin
    bus_rsp         = '0;
    bus_rsp.awready = wr_go;
    bus_rsp.wready  = wr_go;
    bus_rsp.bvalid  = st.bvalid;
    bus_rsp.bresp   = st.bresp;
    bus_rsp.arready = rd_go;
    bus_rsp.rvalid  = st.rvalid;
    bus_rsp.rdata   = st.rdata;
    bus_rsp.rresp   = st.rresp;
  end

  // Edges only from the synchronised stage, never the first flop
  assign rise     = st.ref_pipe[1] && !st.ref_pipe[2];
  assign ref_edge = st.dbl ? (st.ref_pipe[1] != st.ref_pipe[2]) : rise;
  assign pre_hit  = ref_edge && (st.pre_cnt + 8'h01 >= st.pre_div);
  assign indicator = st.lock_indicator_type ? (!st.busy_pipe[1] && st.lock_pipe[1])
                                : !st.busy_pipe[1];

  // ========================================================================
  // Next state
  always_comb begin
    nx           = st;
    nx.ref_pipe  = {st.ref_pipe[1:0], reference_input};
    nx.busy_pipe = {st.busy_pipe[0], cal_busy_pin};
    nx.lock_pipe = {st.lock_pipe[0], vtune_locked_pin};
    nx.pd_tick   = 1'b0;
    nx.smt       = 1'b0;
    nx.cal       = 1'b0;
    nx.mod_clear = 1'b0;
    nx.phase_add = 1'b0;
    wv           = '0;

    if (ref_edge) begin
      nx.pre_cnt = pre_hit ? 8'h00 : st.pre_cnt + 8'h01;
    end
    if (pre_hit) begin
      if (st.post_cnt + 8'h01 >= st.post_div) begin
        nx.post_cnt = 8'h00;
        nx.pd_tick  = 1'b1;
      end else begin
        nx.post_cnt = st.post_cnt + 8'h01;
      end
    end
    if (rise) begin
      if (st.sm_cnt == 5'((6'h01 << st.sm_code) - 6'h01)) begin
        nx.sm_cnt = 5'h00;
        nx.smt    = 1'b1;
      end else begin
        nx.sm_cnt = st.sm_cnt + 5'h01;
      end
    end
    nx.pin = st.sel ? indicator : readback_bit;

    if (st.bvalid && bus_req.bready) begin
      nx.bvalid = 1'b0;
    end
    if (st.rvalid && bus_req.rready) begin
      nx.rvalid = 1'b0;
    end

    if (wr_go) begin
      nx.bvalid = 1'b1;
      nx.bresp  = RESP_OK;
      case (bus_req.awaddr)
        REG_CTRL0: begin
          wv           = merge(ctrl_word(st), bus_req.wdata, bus_req.wstrb);
          nx.dbl       = wv[DBL_BIT];
          nx.sel       = wv[SEL_BIT];
          nx.order     = wv[ORDER_LSB +: 2];
          nx.lock_indicator_type = wv[LDTYPE_BIT];
          nx.sync_mode = wv[SYNC_BIT];
          // Calibration start is a strobe, it reads back as zero
          nx.cal       = wv[CAL_BIT];
          nx.mod_clear = 1'b1;
        end
        REG_REFDIV: begin
          wv          = merge(refdiv_word(st), bus_req.wdata, bus_req.wstrb);
          nx.pre_div  = clamp_div(wv[PRE_LSB +: 8], PRE_MAX);
          // Post input limit is left to software
          nx.post_div = clamp_div(wv[POST_LSB +: 8], POST_MAX);
          nx.sm_code  = (wv[SMDIV_LSB +: 3] > SM_MAX) ? SM_MAX
                                                      : wv[SMDIV_LSB +: 3];
          nx.dly      = wv[DLY_LSB +: 3];
          nx.pre_cnt  = 8'h00;
          nx.post_cnt = 8'h00;
          nx.sm_cnt   = 5'h00;
        end
        REG_NINT: begin
          wv      = merge({13'h0000, st.nint}, bus_req.wdata, bus_req.wstrb);
          nx.nint = (wv[18:0] < NINT_MIN) ? NINT_MIN : wv[18:0];
        end
        REG_NUM: begin
          nx.num = merge(st.num, bus_req.wdata, bus_req.wstrb);
        end
        REG_BOTTOM: begin
          wv        = merge(st.bottom, bus_req.wdata, bus_req.wstrb);
          nx.bottom = (wv == '0) ? 32'h00000001 : wv;
        end
        REG_EXTRA: begin
          wv       = merge({24'h000000, st.extra}, bus_req.wdata, bus_req.wstrb);
          nx.extra = clamp_div(wv[7:0], POST_MAX);
        end
        REG_PHASE: begin
          nx.phase_step = merge(st.phase_step, bus_req.wdata, bus_req.wstrb);
          nx.phase_add  = 1'b1;
        end
        default: begin
          nx.bresp = RESP_ERR;
        end
      endcase
    end

    if (rd_go) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OK;
      case (bus_req.araddr)
        REG_CTRL0:  nx.rdata = ctrl_word(st);
        REG_REFDIV: nx.rdata = refdiv_word(st);
        REG_NINT:   nx.rdata = {13'h0000, st.nint};
        REG_NUM:    nx.rdata = st.num;
        REG_BOTTOM: nx.rdata = st.bottom;
        REG_EXTRA:  nx.rdata = {24'h000000, st.extra};
        REG_PHASE:  nx.rdata = st.phase_step;
        REG_STATUS: begin
          nx.rdata           = {11'h000, mod_divide};
          nx.rdata[ST_BUSY]  = st.busy_pipe[1];
          nx.rdata[ST_LOCK]  = st.lock_pipe[1];
          nx.rdata[ST_PIN]   = st.pin;
        end
        default: begin
          nx.rdata = '0;
          nx.rresp = RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= ST_RST;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  // ========================================================================
  // Feedback modulator
  fraction_modulator u_mod (
    .core_clk   (core_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .clear      (st.mod_clear),
    .tick       (st.pd_tick),
    .order      (st.order),
    .nint       (st.nint),
    .num        (st.num),
    .bottom     (st.bottom),
    .phase_add  (st.phase_add),
    .phase_step (st.phase_step),
    .divide     (mod_divide)
  );

  // ========================================================================
  // Outputs
  // pin always driven
  assign status_pin_oe         = 1'b1;
  assign status_pin_out        = st.pin;
  assign detector_tick         = st.pd_tick;
  assign sm_tick               = st.smt;
  assign calibration_start     = st.cal;
  assign modulator_order       = st.order;
  assign detector_delay_select = st.dly;
  // extra factor forced to one outside sync
  assign feedback_extra_factor = st.sync_mode ? st.extra : 8'h01;
  assign feedback_divide       = mod_divide;

  // ========================================================================
  // Checks
  chk_pin_driven: assert property (@(posedge core_clk) disable iff (reset)
    status_pin_oe)
    else $error("status pin released");
  chk_pin_readback: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !st.sel) |=> status_pin_out == $past(readback_bit))
    else $error("readback not on status pin");
  chk_pin_lock: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && st.sel && !st.lock_indicator_type) |=> status_pin_out == !$past(st.busy_pipe[1]))
    else $error("lock indicator not on status pin");
  chk_mod_clear: assert property (@(posedge core_clk) disable iff (reset)
    (wr_go && bus_req.awaddr == REG_CTRL0) |=> st.mod_clear)
    else $error("register zero write did not clear modulator");
  chk_extra_one: assert property (@(posedge core_clk) disable iff (reset)
    !st.sync_mode |-> feedback_extra_factor == 8'h01)
    else $error("extra factor above one outside sync");
  chk_pre_range: assert property (@(posedge core_clk) disable iff (reset)
    st.pre_div >= 8'h01 && st.pre_div <= PRE_MAX)
    else $error("pre divide out of range");
  chk_nint_floor: assert property (@(posedge core_clk) disable iff (reset)
    st.nint >= NINT_MIN && st.bottom != '0)
    else $error("integer or bottom out of range");
  chk_pd_rate: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && ref_edge && st.pre_div == 8'h01 && st.post_div == 8'h01)
      |=> detector_tick)
    else $error("bypassed path missed a detector tick");
  chk_sm_bypass: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && rise && st.sm_code == 3'h0) |=> sm_tick)
    else $error("state machine clock missed divide by one");
endmodule : fractional_n_divider_config
`default_nettype wire
